// ==== hdl/fll_bod_regs.sv ====
// AXI4-Lite register slice for the frequency-locked loop values and supply brown-out detector
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// RULE1 - Closed loop reports ideal minus measured count
// RULE2 - Coarse and fine writable only open loop
// RULE3 - Coarse step limit bounds coarse correction
// RULE4 - Fine step limit bounds fine correction
// RULE5 - Multiply factor sets output/reference ratio
// RULE6 - Multiply write clears locks, centres fine
// RULE7 - Refresh request updates value, raises ready
// RULE8 - Level field selects brown-out threshold
// RULE9 - Software changes level only while disabled; the code also takes level writes while enabled
// RULE10 - Prescaler divides 1 kHz by 2^(n+1)
// RULE11 - Sample clock bit reads running or stopping
// RULE12 - Mode bit: continuous or periodic sampling
// RULE13 - Standby bit keeps detector running asleep
// RULE14 - Action: none, reset, interrupt, reserved
// RULE15 - Hysteresis bit widens threshold comparison
// RULE16 - Level and action load from user row
// RULE17 - Enable and hysteresis load from user row
// RULE18 - Reserved bits read zero, written zero
// RULE19 - Loop mode bit selects open or closed
// RULE20 - Sampling compares once per sample period
module fll_bod_regs
   import fll_bod_pkg::*;
#(
   parameter int TICK_CYC = LP_TICK_CYC   // aclk cycles per 1 kHz low-power tick
) (
   input  wire logic        aclk,            // 200 MHz clock
   input  wire logic        aresetn,         // synchronous reset, active low
   input  wire logic [7:0]  s_axi_awaddr,    // write address
   input  wire logic        s_axi_awvalid,   // write address valid
   output logic             s_axi_awready,   // write address ready
   input  wire logic [31:0] s_axi_wdata,     // write data
   input  wire logic [3:0]  s_axi_wstrb,     // write byte strobes
   input  wire logic        s_axi_wvalid,    // write data valid
   output logic             s_axi_wready,    // write data ready
   output logic [1:0]       s_axi_bresp,     // write response
   output logic             s_axi_bvalid,    // write response valid
   input  wire logic        s_axi_bready,    // write response ready
   input  wire logic [7:0]  s_axi_araddr,    // read address
   input  wire logic        s_axi_arvalid,   // read address valid
   output logic             s_axi_arready,   // read address ready
   output logic [31:0]      s_axi_rdata,     // read data
   output logic [1:0]       s_axi_rresp,     // read response
   output logic             s_axi_rvalid,    // read data valid
   input  wire logic        s_axi_rready,    // read data ready
   input  wire logic        row_load,        // user row valid, pulse after reset
   input  wire logic [5:0]  row_level,       // user row threshold level
   input  wire logic [1:0]  row_action,      // user row action
   input  wire logic        row_threshold_hysteresis,        // user row hysteresis
   input  wire logic        row_enable,      // user row enable
   input  wire logic [15:0] loop_ratio_difference_in,    // analog loop ideal minus counted
   input  wire logic [5:0]  loop_coarse_in,  // analog loop live coarse value
   input  wire logic [9:0]  loop_fine_in,    // analog loop live fine value
   input  wire logic        standby,         // standby sleep active
   input  wire logic        supply_low,      // comparator: supply below level
   input  wire logic        supply_low_threshold_hysteresis, // comparator with hysteresis band
   output logic             loop_closed,     // loop in closed-loop operation
   output logic [5:0]       coarse_out,      // coarse calibration to oscillator
   output logic [9:0]       fine_out,        // fine calibration to oscillator
   output logic [5:0]       coarse_step_limit, // max coarse step per correction
   output logic [9:0]       fine_step_limit, // max fine step per correction
   output logic [15:0]      multiply_factor, // target frequency ratio
   output logic             lock_clear,      // drop all locks, one-cycle pulse
   output logic             loop_ready_flag, // refreshed value valid
   output logic [5:0]       bod_level,       // threshold level to comparator
   output logic             bod_threshold_hysteresis_en,     // hysteresis on comparator
   output logic             bod_active,      // detector powered
   output logic             bod_reset,       // brown-out reset request, level
   output logic             bod_irq          // brown-out interrupt, one-cycle pulse
);
   import fll_bod_pkg::*;

   logic [31:0] mult_r;
   logic [15:0] ratio_difference_r;
   logic [5:0]  coarse_r;
   logic [9:0]  fine_r;
   logic        loop_mode_r;
   logic        ready_r;
   logic [2:0]  refresh_cnt_r;
   logic [5:0]  level_r;
   logic [3:0]  psel_r;
   logic        cen_r;
   logic        smode_r;
   logic        stdby_r;
   logic [1:0]  action_r;
   logic        threshold_hysteresis_r;
   logic        enable_r;
   sclk_state_t sc_state_r;
   logic [1:0]  sc_cnt_r;
   logic [31:0] tick_cnt_r;
   logic [15:0] pre_cnt_r;
   logic        low_r;
   logic        aw_held_r, w_held_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic [31:0] rdata_r;

   // Write channel capture: address and data accepted in either order
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
   wire        aw_fire = s_axi_awvalid && s_axi_awready;
   wire        w_fire  = s_axi_wvalid && s_axi_wready;
   wire        aw_have = aw_held_r || aw_fire;
   wire        w_have  = w_held_r || w_fire;
   wire        wr_do   = aw_have && w_have;
   wire [7:0]  wa      = aw_held_r ? awaddr_r : s_axi_awaddr;
   wire [31:0] wd      = w_held_r ? wdata_r : s_axi_wdata;
   wire [3:0]  ws      = w_held_r ? wstrb_r : s_axi_wstrb;
   wire [31:0] wmask   = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};

   wire wr_value = wr_do && wa == OFS_VALUE;
   wire wr_mult  = wr_do && wa == OFS_MULT;
   wire wr_sync  = wr_do && wa == OFS_SYNC;
   wire wr_bod   = wr_do && wa == OFS_BOD;
   wire wr_lctl  = wr_do && wa == OFS_LOOPCTL;
   wire wr_ok    = wr_value || wr_mult || wr_sync || wr_bod || wr_lctl;

   wire [31:0] mult_nxt  = (mult_r & ~wmask) | (wd & wmask);
   wire        mul_touch = wr_mult && (ws[0] || ws[1]); // RULE6
   // Byte lanes of the value and control registers
   wire [31:0] val_cur   = {ratio_difference_r, coarse_r, fine_r};
   wire [31:0] val_nxt   = (val_cur & ~wmask) | (wd & wmask);
   wire [31:0] bod_cur   = {10'h000, level_r, psel_r, 2'b00, cen_r, smode_r,
                            1'b0, stdby_r, 1'b0, action_r, threshold_hysteresis_r, enable_r, 1'b0};
   wire [31:0] bod_nxt   = (bod_cur & ~wmask) | (wd & wmask);
   wire        req_wr    = wr_sync && ws[0] && wd[SYNC_REQ_BIT]; // RULE7

   // Register writes, refresh and mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mult_r        <= MULT_RESET;
         ratio_difference_r        <= VALUE_RESET[31:16];
         coarse_r      <= VALUE_RESET[15:10];
         fine_r        <= VALUE_RESET[9:0];
         loop_mode_r   <= 1'b0;
         ready_r       <= 1'b1;
         refresh_cnt_r <= 3'h0;
         lock_clear    <= 1'b0;
      end else begin
         lock_clear <= mul_touch; // RULE6
         if (wr_mult)
            mult_r <= mult_nxt; // RULE3 RULE4 RULE5
         if (wr_lctl && ws[0])
            loop_mode_r <= wd[LOOP_MODE_BIT]; // RULE19
         if (wr_value && !loop_mode_r) begin
            coarse_r <= val_nxt[15:10]; // RULE2
            fine_r   <= val_nxt[9:0];
         end
         if (mul_touch)
            fine_r <= FINE_MID; // RULE6
         // Refresh takes a few cycles, standing in for the loop-domain sync
         if (req_wr && loop_mode_r) begin
            ready_r       <= 1'b0;
            refresh_cnt_r <= 3'(REFRESH_CYC);
         end else if (refresh_cnt_r != 3'h0) begin
            refresh_cnt_r <= refresh_cnt_r - 3'h1;
            if (refresh_cnt_r == 3'h1) begin
               ratio_difference_r   <= loop_ratio_difference_in; // RULE1
               coarse_r <= loop_coarse_in;
               if (!mul_touch)
                  fine_r <= loop_fine_in;
               ready_r  <= 1'b1; // RULE7
            end
         end
      end
   end

   // Brown-out control fields; a user row load wins over a bus write in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_r  <= 6'h00;
         psel_r   <= 4'h0;
         cen_r    <= 1'b0;
         smode_r  <= 1'b0;
         stdby_r  <= 1'b0;
         action_r <= ACT_NONE;
         threshold_hysteresis_r   <= 1'b0;
         enable_r <= 1'b0;
      end else if (row_load) begin
         level_r  <= row_level; // RULE16
         action_r <= row_action;
         threshold_hysteresis_r   <= row_threshold_hysteresis; // RULE17
         enable_r <= row_enable;
      end else if (wr_bod) begin
         level_r  <= bod_nxt[LEVEL_LSB +: 6]; // RULE8
         psel_r   <= bod_nxt[PSEL_LSB +: 4]; // RULE10
         cen_r    <= bod_nxt[CEN_BIT]; // RULE11
         smode_r  <= bod_nxt[MODE_BIT]; // RULE12
         stdby_r  <= bod_nxt[STDBY_BIT]; // RULE13
         action_r <= bod_nxt[ACTION_LSB +: 2]; // RULE14
         threshold_hysteresis_r   <= bod_nxt[THRESHOLD_HYSTERESIS_BIT]; // RULE15
         enable_r <= bod_nxt[ENABLE_BIT];
      end
   end

   // Sampling clock start/stop: status lags the control bit by a short sync
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sc_state_r <= SC_OFF;
         sc_cnt_r   <= 2'h0;
      end else begin
         case (sc_state_r)
            SC_OFF: if (cen_r) begin
               sc_state_r <= SC_STARTING;
               sc_cnt_r   <= 2'(CEN_SYNC_CYC);
            end
            SC_STARTING: if (!cen_r) begin
               sc_state_r <= SC_OFF;
            end else if (sc_cnt_r == 2'h1) begin
               sc_state_r <= SC_RUN;
            end else begin
               sc_cnt_r <= sc_cnt_r - 2'h1;
            end
            SC_RUN: if (!cen_r) begin
               sc_state_r <= SC_STOPPING;
               sc_cnt_r   <= 2'(CEN_SYNC_CYC);
            end
            SC_STOPPING: if (sc_cnt_r == 2'h1) begin
               sc_state_r <= SC_OFF;
            end else begin
               sc_cnt_r <= sc_cnt_r - 2'h1;
            end
            default: sc_state_r <= SC_OFF;
         endcase
      end
   end
   wire cen_status = sc_state_r == SC_RUN || sc_state_r == SC_STOPPING; // RULE11
   wire sclk_run   = sc_state_r == SC_RUN;

   // 1 kHz tick enable and prescaler; divide by 2^(psel+1)
   wire        lp_tick   = tick_cnt_r == 32'(TICK_CYC - 1);
   wire [15:0] pre_mask  = 16'((32'h2 << psel_r) - 32'h1); // RULE10
   wire        samp_tick = sclk_run && lp_tick && ((pre_cnt_r & pre_mask) == pre_mask);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_r <= 32'h0;
         pre_cnt_r  <= 16'h0;
      end else begin
         tick_cnt_r <= lp_tick ? 32'h0 : tick_cnt_r + 32'h1;
         if (!sclk_run)
            pre_cnt_r <= 16'h0;
         else if (lp_tick)
            pre_cnt_r <= pre_cnt_r + 16'h1;
      end
   end

   // Detector: continuous compare, or one compare per sample period
   assign bod_active = enable_r && (!standby || stdby_r); // RULE13
   wire   cmp_low    = threshold_hysteresis_r ? supply_low_threshold_hysteresis : supply_low; // RULE15
   wire   do_compare = bod_active && (!smode_r || samp_tick); // RULE12 RULE20
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_r   <= 1'b0;
         bod_irq <= 1'b0;
      end else begin
         bod_irq <= 1'b0;
         if (!bod_active) begin
            low_r <= 1'b0;
         end else if (do_compare) begin
            low_r <= cmp_low;
            if (cmp_low && !low_r && action_r == ACT_IRQ)
               bod_irq <= 1'b1; // RULE14
         end
      end
   end
   // Reserved action code behaves as no action
   assign bod_reset = low_r && action_r == ACT_RESET; // RULE14

   assign loop_closed       = loop_mode_r;
   assign coarse_out        = coarse_r;
   assign fine_out          = fine_r;
   assign coarse_step_limit = mult_r[COARSE_STEP_LIMIT_LSB +: 6]; // RULE3
   assign fine_step_limit   = mult_r[FINE_STEP_LIMIT_LSB +: 10]; // RULE4
   assign multiply_factor   = mult_r[15:0]; // RULE5
   assign loop_ready_flag   = ready_r; // RULE7
   assign bod_level         = level_r;
   assign bod_threshold_hysteresis_en       = threshold_hysteresis_r;

   // Read decode; reserved bits come back as zero
   wire [31:0] val_rd  = {loop_mode_r ? ratio_difference_r : 16'h0000, coarse_r, fine_r}; // RULE1
   wire [31:0] bod_rd  = {bod_cur[31:10], cen_status, bod_cur[8:0]}; // RULE18
   wire        rd_map  = s_axi_araddr == OFS_VALUE || s_axi_araddr == OFS_MULT ||
                         s_axi_araddr == OFS_SYNC || s_axi_araddr == OFS_BOD ||
                         s_axi_araddr == OFS_LOOPCTL || s_axi_araddr == OFS_STATUS;
   wire [31:0] rd_mux  =
      s_axi_araddr == OFS_VALUE   ? val_rd :
      s_axi_araddr == OFS_MULT    ? mult_r :
      s_axi_araddr == OFS_BOD     ? bod_rd :
      s_axi_araddr == OFS_LOOPCTL ? {29'h0, loop_mode_r, 2'b00} :
      s_axi_araddr == OFS_STATUS  ? {30'h0, low_r, ready_r} :
      32'h0000_0000; // RULE18
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rdata   = rdata_r;

   // Bus handshake state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r    <= 1'b0;
         w_held_r     <= 1'b0;
         awaddr_r     <= 8'h00;
         wdata_r      <= 32'h0;
         wstrb_r      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= RESP_OKAY;
         rdata_r      <= 32'h0;
      end else begin
         if (wr_do) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else begin
            if (aw_fire) begin
               aw_held_r <= 1'b1;
               awaddr_r  <= s_axi_awaddr;
            end
            if (w_fire) begin
               w_held_r <= 1'b1;
               wdata_r  <= s_axi_wdata;
               wstrb_r  <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
               s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            rdata_r      <= rd_mux;
            s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : fll_bod_regs

// ==== hdl/fll_bod_pkg.sv ====
// Register map, field positions and timing constants for the loop and brown-out slice
package fll_bod_pkg;
   localparam logic [7:0]  OFS_VALUE      = 8'h28;
   localparam logic [7:0]  OFS_MULT       = 8'h2c;
   localparam logic [7:0]  OFS_SYNC       = 8'h30;
   localparam logic [7:0]  OFS_BOD        = 8'h34;
   localparam logic [7:0]  OFS_LOOPCTL    = 8'h38;
   localparam logic [7:0]  OFS_STATUS     = 8'h3c;
   localparam int          RATIO_DIFFERENCE_LSB       = 16;
   localparam int          COARSE_LSB     = 10;
   localparam int          COARSE_STEP_LIMIT_LSB      = 26;
   localparam int          FINE_STEP_LIMIT_LSB      = 16;
   localparam int          SYNC_REQ_BIT   = 7;
   localparam int          LEVEL_LSB      = 16;
   localparam int          PSEL_LSB       = 12;
   localparam int          CEN_BIT        = 9;
   localparam int          MODE_BIT       = 8;
   localparam int          STDBY_BIT      = 6;
   localparam int          ACTION_LSB     = 3;
   localparam int          THRESHOLD_HYSTERESIS_BIT       = 2;
   localparam int          ENABLE_BIT     = 1;
   localparam int          LOOP_MODE_BIT  = 2;
   localparam logic [31:0] MULT_RESET     = 32'h0000_0000;
   localparam logic [31:0] VALUE_RESET    = 32'h0000_0000;
   localparam logic [9:0]  FINE_MID       = 10'h200;
   localparam logic [1:0]  ACT_NONE       = 2'h0;
   localparam logic [1:0]  ACT_RESET      = 2'h1;
   localparam logic [1:0]  ACT_IRQ        = 2'h2;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam int          CLK_HZ         = 200_000_000;
   localparam int          LP_CLK_HZ      = 1_000;
   localparam int          LP_TICK_CYC    = CLK_HZ / LP_CLK_HZ;
   localparam int          REFRESH_CYC    = 4;
   localparam int          CEN_SYNC_CYC   = 2;
   typedef enum logic [1:0] {
      SC_OFF      = 2'b00,
      SC_STARTING = 2'b01,
      SC_RUN      = 2'b10,
      SC_STOPPING = 2'b11
   } sclk_state_t;
endpackage : fll_bod_pkg

// ==== tb/fll_bod_regs_checker.sv ====
// Bus handshake and side-effect assertions for the loop and brown-out register slice
`timescale 1ns/1ps
module fll_bod_regs_checker
   import fll_bod_pkg::*;
(
   input wire logic        aclk,            // clock
   input wire logic        aresetn,         // sync reset, active low
   input wire logic        s_axi_awready,   // write address ready
   input wire logic        s_axi_wready,    // write data ready
   input wire logic [1:0]  s_axi_bresp,     // write response
   input wire logic        s_axi_bvalid,    // write response valid
   input wire logic        s_axi_bready,    // write response ready
   input wire logic        s_axi_arready,   // read address ready
   input wire logic [31:0] s_axi_rdata,     // read data
   input wire logic        s_axi_rvalid,    // read data valid
   input wire logic        s_axi_rready,    // read data ready
   input wire logic [9:0]  fine_out,        // fine calibration
   input wire logic [15:0] multiply_factor, // target ratio
   input wire logic        lock_clear,      // lock drop pulse
   input wire logic        loop_ready_flag, // refreshed value valid
   input wire logic        loop_closed,     // closed-loop mode
   input wire logic        bod_reset,       // brown-out reset request
   input wire logic        bod_irq          // brown-out interrupt pulse
);
   import fll_bod_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   write_once_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   read_once_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   lock_pulse_a: assert property (lock_clear |-> fine_out == FINE_MID ##1 !lock_clear)
      else $error("lock clear pulse or fine centring wrong");
   mult_lock_a: assert property ($changed(multiply_factor) |-> ##[0:1] lock_clear)
      else $error("factor changed without lock clear");
   refresh_ready_a: assert property ($fell(loop_ready_flag) |-> loop_closed ##[1:5] loop_ready_flag)
      else $error("refresh flag not back in time");
   bod_excl_a: assert property (bod_irq |-> !bod_reset ##1 !bod_irq)
      else $error("interrupt not a lone pulse");
endmodule : fll_bod_regs_checker

bind fll_bod_regs fll_bod_regs_checker chk_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .fine_out, .multiply_factor, .lock_clear, .loop_ready_flag, .loop_closed,
   .bod_reset, .bod_irq);

// ==== tb/testbench.sv ====
// Register-level testbench for the loop and brown-out register slice
`timescale 1ns/1ps
module testbench;
   import fll_bod_pkg::*;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, row_load, row_threshold_hysteresis, row_enable, standby, supply_low;
   logic        supply_low_threshold_hysteresis, loop_closed, lock_clear, loop_ready_flag, bod_threshold_hysteresis_en;
   logic        bod_active, bod_reset, bod_irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, row_action, r;
   logic [5:0]  row_level, loop_coarse_in, coarse_out, coarse_step_limit, bod_level;
   logic [9:0]  loop_fine_in, fine_out, fine_step_limit;
   logic [15:0] loop_ratio_difference_in, multiply_factor;
   int          errors, compares, i0, l0, p;
   int          irqs = 0, locks = 0;

   fll_bod_regs #(.TICK_CYC(4)) fll_bod_regs_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .row_load, .row_level, .row_action, .row_threshold_hysteresis,
      .row_enable, .loop_ratio_difference_in, .loop_coarse_in, .loop_fine_in, .standby, .supply_low,
      .supply_low_threshold_hysteresis, .loop_closed, .coarse_out, .fine_out, .coarse_step_limit,
      .fine_step_limit, .multiply_factor, .lock_clear, .loop_ready_flag, .bod_level,
      .bod_threshold_hysteresis_en, .bod_active, .bod_reset, .bod_irq);

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      if (bod_irq === 1'b1) irqs <= irqs + 1;
      if (lock_clear === 1'b1) locks <= locks + 1;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask : wt

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Both channels offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      for (n = 0; n < 1000; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 1000) errors++;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      for (n = 0; n < 1000; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      v = s_axi_rdata; r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 1000) errors++;
   endtask : rd

   task automatic low(input logic b);
      supply_low <= b; supply_low_threshold_hysteresis <= b;
   endtask : low

   task automatic close_out;
      if (errors == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out

   initial begin
      #300000;
      errors++;
      close_out;
   end

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {row_load, row_threshold_hysteresis, row_enable, standby, supply_low, supply_low_threshold_hysteresis} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, row_action, row_level} = '0;
      {loop_ratio_difference_in, loop_coarse_in, loop_fine_in, errors, compares} = '0;
      wt(10);
      aresetn <= 1'b1;
      rd(OFS_MULT); chk("mult reset", v, 32'h0);
      rd(OFS_BOD); chk("bod reset", v, 32'h0);
      rd(OFS_STATUS); chk("ready reset", {31'h0, v[0]}, 32'h1);
      row_level <= 6'h2a; row_action <= 2'h1; row_threshold_hysteresis <= 1'b1; row_enable <= 1'b1;
      row_load <= 1'b1;
      wt(1);
      row_load <= 1'b0;
      rd(OFS_BOD); chk("row load", v, 32'h002a000e);
      chk("row pins", {bod_level, bod_threshold_hysteresis_en, bod_active}, {6'h2a, 2'h3});
      wr(OFS_BOD, 32'h002a0000);
      wr(OFS_BOD, 32'hfffffffc);
      wt(3);
      rd(OFS_BOD); chk("bod fields", v, 32'h003ff35c);
      chk("level pins", {bod_level, bod_threshold_hysteresis_en}, {6'h3f, 1'b1});
      wr(OFS_BOD, 32'h002a0000);
      rd(OFS_BOD); chk("clock stopping", v[9], 1'b1);
      wt(3);
      rd(OFS_BOD); chk("clock stopped", v, 32'h002a0000);
      chk("threshold_hysteresis off", bod_threshold_hysteresis_en, 1'b0);
      for (int k = 0; k < 2; k++) begin
         wr(OFS_BOD, 32'h002a0002 | (k << 6));
         standby <= 1'b1;
         wt(2);
         chk("standby run", bod_active, k[0]);
         standby <= 1'b0;
      end
      for (int a = 0; a < 4; a++) begin
         wr(OFS_BOD, 32'h002a0002 | (a << 3));
         i0 = irqs;
         low(1'b1);
         wt(10);
         chk("reset req", bod_reset, a == 1);
         chk("irq count", irqs - i0, a == 2);
         low(1'b0);
         wt(10);
      end
      // Hysteresis selects the banded comparator output
      wr(OFS_BOD, 32'h002a000e);
      supply_low <= 1'b1;
      wt(4);
      chk("threshold_hysteresis input", bod_reset, 1'b0);
      supply_low_threshold_hysteresis <= 1'b1;
      wt(4);
      chk("threshold_hysteresis trip", bod_reset, 1'b1);
      low(1'b0);
      wt(4);
      for (int c = 0; c < 2; c++) begin
         wr(OFS_BOD, 32'h002a0112 | (c << 9));
         wt(5);
         i0 = irqs;
         low(1'b1);
         wt(40);
         chk("sampled irq", irqs - i0, c);
         low(1'b0);
         wt(20);
      end
      // Prescaler code 1: one sample every 4 ticks of 4 cycles
      wr(OFS_BOD, 32'h002a130a);
      low(1'b1);
      for (p = 0; p < 100 && bod_reset !== 1'b1; p++) wt(1);
      low(1'b0);
      for (p = 0; p < 100 && bod_reset === 1'b1; p++) wt(1);
      chk("sample period", p, 2 ** (1 + 1) * 4);
      l0 = locks;
      wr(OFS_MULT, 32'habcd1234);
      rd(OFS_MULT); chk("mult rw", v, 32'habcd1234);
      chk("steps", {coarse_step_limit, fine_step_limit}, {6'h2a, 10'h3cd});
      chk("factor", multiply_factor, 16'h1234);
      chk("fine mid", fine_out, 10'h200);
      wr(OFS_MULT, 32'h04010000, 4'hc);
      chk("lock pulses", locks - l0, 1);
      wr(OFS_VALUE, 32'hffffa5f3);
      rd(OFS_VALUE); chk("open value", v, 32'h0000a5f3);
      chk("cal out", {coarse_out, fine_out}, {6'h29, 10'h1f3});
      wr(OFS_LOOPCTL, 32'h4);
      chk("closed", loop_closed, 1'b1);
      wr(OFS_VALUE, 32'h0);
      chk("cal locked", {coarse_out, fine_out}, {6'h29, 10'h1f3});
      loop_ratio_difference_in <= 16'h8001; loop_coarse_in <= 6'h15; loop_fine_in <= 10'h2aa;
      wr(OFS_SYNC, 32'h80);
      rd(OFS_STATUS); chk("ready low", v[0], 1'b0);
      for (int n = 0; n < 20; n++) begin
         rd(OFS_STATUS);
         if (v[0] === 1'b1) break;
      end
      rd(OFS_VALUE); chk("refresh", v, 32'h800156aa);
      chk("ready pin", loop_ready_flag, 1'b1);
      wr(8'h80, 32'h1); chk("unmapped wr", r, RESP_SLVERR);
      rd(8'h80); chk("unmapped rd", r, RESP_SLVERR);
      close_out;
   end
endmodule : testbench
